// ==== inc/aom_params.svh ====
// Purpose: constants of the angle output mapper
// Assumes: one 125 MHz clock
// Notes: offsets are byte addresses on the plain register port
`ifndef AOM_PARAMS_SVH
`define AOM_PARAMS_SVH

// ********************************
// widths
// ********************************
`define AOM_ANGLE_W 14
`define AOM_CODE_W 12
`define AOM_CLAMP_W 9
`define AOM_OTP_W 128
`define AOM_ADDR_W 8
`define AOM_DATA_W 32
`define AOM_CLAMP_SHIFT 3

// ********************************
// register offsets and control bits
// ********************************
`define AOM_OFS_START 8'h00
`define AOM_OFS_END 8'h04
`define AOM_OFS_YSTART 8'h08
`define AOM_OFS_YEND 8'h0c
`define AOM_OFS_CLL 8'h10
`define AOM_OFS_CLH 8'h14
`define AOM_OFS_BP 8'h18
`define AOM_OFS_CTRL 8'h1c
`define AOM_OFS_STATUS 8'h20
`define AOM_OFS_BURN 8'h24
`define AOM_CTRL_INV 0
`define AOM_CTRL_BAND 1
`define AOM_CTRL_LOCK 2
`define AOM_BURN_GO 0

// ********************************
// shadow reset values
// ********************************
`define AOM_RST_START 14'h0000
`define AOM_RST_END 14'h3fff
`define AOM_RST_YSTART 12'h000
`define AOM_RST_YEND 12'hfff
`define AOM_RST_CLL 9'h020
`define AOM_RST_CLH 9'h1d8
`define AOM_RST_BP 14'h0000

// ********************************
// failure bands and timing
// ********************************
`define AOM_BAND_LO_CODE 12'h000
`define AOM_BAND_HI_CODE 12'hfff
`define AOM_BAND_LO_MAX 12'h0a3
`define AOM_BAND_HI_MIN 12'hf5d
`define AOM_CLK_MHZ 125
`define AOM_OV_DET_US 50
`define AOM_OV_REC_US 50
`define AOM_UV_DET_US 50
`define AOM_UV_REC_US 50

`endif

// ==== inc/aom_pkg.sv ====
// Purpose: types of the angle output mapper
// Assumes: aom_params.svh gives the widths
// Notes: settings travel as one packed struct
`include "aom_params.svh"
package aom_pkg;

    // ********************************
    // supply monitor states, gray along the path
    // ********************************
    typedef enum logic [1:0] {
        AOM_SUP_NORMAL = 2'h0,
        AOM_SUP_OV_OFF = 2'h1,
        AOM_SUP_UV_OFF = 2'h2
    } aom_sup_e;

    // ********************************
    // output characteristic settings
    // ********************************
    typedef struct packed {
        logic lock;
        logic band_high;
        logic invert;
        logic [`AOM_ANGLE_W-1:0] wrap_break_point;
        logic [`AOM_CLAMP_W-1:0] clamp_high_level;
        logic [`AOM_CLAMP_W-1:0] clamp_low_level;
        logic [`AOM_CODE_W-1:0] end_output_level;
        logic [`AOM_CODE_W-1:0] start_output_level;
        logic [`AOM_ANGLE_W-1:0] angle_end_point;
        logic [`AOM_ANGLE_W-1:0] angle_start_point;
    } aom_cfg_s;

endpackage

// ==== src/aom_top.sv ====
// Purpose: angle code to output level mapper with supply monitor and diagnostics
// Assumes: angle code from logic on clk; comparator and alarm flags are asynchronous
// Notes: drive_en low means the output driver is in high impedance
//
// Overview of operation
// - overvoltage held past detection time: output off
// - below overvoltage low past recovery: output on
// - undervoltage held past detection time: output off
// - above undervoltage high past time: output on
// - angle is a 14-bit unsigned code
// - result drives a 12-bit supply-referenced converter
// - start and end angles are 14 bits
// - start and end levels are 12 bits
// - linear map between pairs, extended to clamps
// - separate independent 9-bit low/high clamps
// - break point jumps between high and low clamp
// - break point moves the angle wrap position
// - optional slope inversion
// - shadow settings writable until locked, reset on power
// - locked store frozen until a reset clears it, writes ignored
// - settings stored in 128-bit one-time store
// - analog output mode once lock is set
// - short circuit puts driver in high impedance
// - failure gives high impedance or failure band
// - bands are 0-4 and 96-100 percent
// - selection bit picks high or low band
`include "aom_params.svh"
`timescale 1ns/100ps
module aom_top #(
    parameter int CNT_W = 16,
    parameter int OV_DET_CYC = `AOM_OV_DET_US * `AOM_CLK_MHZ,
    parameter int OV_REC_CYC = `AOM_OV_REC_US * `AOM_CLK_MHZ,
    parameter int UV_DET_CYC = `AOM_UV_DET_US * `AOM_CLK_MHZ,
    parameter int UV_REC_CYC = `AOM_UV_REC_US * `AOM_CLK_MHZ
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [`AOM_ADDR_W-1:0] reg_addr,
    input wire logic [`AOM_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`AOM_DATA_W-1:0] reg_rdata,
    // angle from the front end
    input wire logic [`AOM_ANGLE_W-1:0] angle_code,
    input wire logic angle_valid,
    // asynchronous supply comparators
    input wire logic ov_above_upper,
    input wire logic ov_above_lower,
    input wire logic uv_below_lower,
    input wire logic uv_above_upper,
    // asynchronous fault flags
    input wire logic short_circuit,
    input wire logic [4:0] internal_alarm,
    // converter and driver
    output logic [`AOM_CODE_W-1:0] dac_code,
    output logic drive_en
);

    localparam int SYNC_W = 10;
    localparam logic [CNT_W-1:0] OV_DET = CNT_W'(OV_DET_CYC);
    localparam logic [CNT_W-1:0] OV_REC = CNT_W'(OV_REC_CYC);
    localparam logic [CNT_W-1:0] UV_DET = CNT_W'(UV_DET_CYC);
    localparam logic [CNT_W-1:0] UV_REC = CNT_W'(UV_REC_CYC);

    // ********************************
    // reset release and input synchronisers
    // ********************************
    logic [1:0] rst_pipe_reg;
    logic rst_n;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic ov_hi_s;
    logic ov_lo_s;
    logic uv_lo_s;
    logic uv_hi_s;
    logic sc_s;
    logic alarm_s;

    // reset asserts at once, releases after two edges
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_reg[1];

    // only the second stage is read by logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {internal_alarm, short_circuit, uv_above_upper,
                          uv_below_lower, ov_above_lower, ov_above_upper};
            sync2_reg <= sync1_reg;
        end
    end
    assign ov_hi_s = sync2_reg[0];
    assign ov_lo_s = sync2_reg[1];
    assign uv_lo_s = sync2_reg[2];
    assign uv_hi_s = sync2_reg[3];
    assign sc_s = sync2_reg[4];
    assign alarm_s = |sync2_reg[9:5];

    // ********************************
    // register port decode
    // ********************************
    aom_pkg::aom_cfg_s shadow_reg;
    aom_pkg::aom_cfg_s cfg;
    logic [`AOM_OTP_W-1:0] otp_reg;
    aom_pkg::aom_cfg_s otp_cfg;
    logic locked;
    logic wr_ok;
    logic burn;
    logic [`AOM_DATA_W-1:0] rd_mux;
    logic [`AOM_DATA_W-1:0] status_word;
    aom_pkg::aom_sup_e sup_reg;

    assign otp_cfg = aom_pkg::aom_cfg_s'(otp_reg[$bits(aom_pkg::aom_cfg_s)-1:0]);
    assign locked = otp_cfg.lock;
    assign wr_ok = reg_wr && !locked;
    assign burn = wr_ok && reg_addr == `AOM_OFS_BURN && reg_wdata[`AOM_BURN_GO];
    // once locked the frozen store runs the analog characteristic
    assign cfg = locked ? otp_cfg : shadow_reg;
    assign status_word = {12'h000, sup_reg, sc_s, alarm_s, drive_en, locked, 2'h0, dac_code};

    // read selection, unmapped offsets read zero
    always_comb begin
        unique case (reg_addr)
            `AOM_OFS_START: rd_mux = 32'(cfg.angle_start_point);
            `AOM_OFS_END: rd_mux = 32'(cfg.angle_end_point);
            `AOM_OFS_YSTART: rd_mux = 32'(cfg.start_output_level);
            `AOM_OFS_YEND: rd_mux = 32'(cfg.end_output_level);
            `AOM_OFS_CLL: rd_mux = 32'(cfg.clamp_low_level);
            `AOM_OFS_CLH: rd_mux = 32'(cfg.clamp_high_level);
            `AOM_OFS_BP: rd_mux = 32'(cfg.wrap_break_point);
            `AOM_OFS_CTRL: rd_mux = 32'({cfg.lock, cfg.band_high, cfg.invert});
            `AOM_OFS_STATUS: rd_mux = status_word;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // shadow returns to defaults on every reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow_reg.angle_start_point <= `AOM_RST_START;
            shadow_reg.angle_end_point <= `AOM_RST_END;
            shadow_reg.start_output_level <= `AOM_RST_YSTART;
            shadow_reg.end_output_level <= `AOM_RST_YEND;
            shadow_reg.clamp_low_level <= `AOM_RST_CLL;
            shadow_reg.clamp_high_level <= `AOM_RST_CLH;
            shadow_reg.wrap_break_point <= `AOM_RST_BP;
            shadow_reg.invert <= 1'b0;
            shadow_reg.band_high <= 1'b0;
            shadow_reg.lock <= 1'b0;
        end else if (wr_ok) begin
            unique case (reg_addr)
                `AOM_OFS_START: shadow_reg.angle_start_point <= reg_wdata[13:0];
                `AOM_OFS_END: shadow_reg.angle_end_point <= reg_wdata[13:0];
                `AOM_OFS_YSTART: shadow_reg.start_output_level <= reg_wdata[11:0];
                `AOM_OFS_YEND: shadow_reg.end_output_level <= reg_wdata[11:0];
                `AOM_OFS_CLL: shadow_reg.clamp_low_level <= reg_wdata[8:0];
                `AOM_OFS_CLH: shadow_reg.clamp_high_level <= reg_wdata[8:0];
                `AOM_OFS_BP: shadow_reg.wrap_break_point <= reg_wdata[13:0];
                `AOM_OFS_CTRL: begin
                    shadow_reg.invert <= reg_wdata[`AOM_CTRL_INV];
                    shadow_reg.band_high <= reg_wdata[`AOM_CTRL_BAND];
                    shadow_reg.lock <= reg_wdata[`AOM_CTRL_LOCK];
                end
                default: ;
            endcase
        end
    end

    // one-time store; a burn while unlocked copies the shadow in
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            otp_reg <= '0;
        end else if (burn) begin
            otp_reg <= `AOM_OTP_W'(shadow_reg);
        end
    end

    // ********************************
    // supply monitor
    // ********************************
    logic [CNT_W-1:0] ov_cnt_reg;
    logic [CNT_W-1:0] uv_cnt_reg;
    logic ov_cond;
    logic uv_cond;
    logic ov_done;
    logic uv_done;
    aom_pkg::aom_sup_e sup_next;

    // condition watched depends on the state; each counter is reused for recovery
    assign ov_cond = (sup_reg == aom_pkg::AOM_SUP_NORMAL) ? ov_hi_s :
                     (sup_reg == aom_pkg::AOM_SUP_OV_OFF) && !ov_lo_s;
    assign uv_cond = (sup_reg == aom_pkg::AOM_SUP_NORMAL) ? uv_lo_s :
                     (sup_reg == aom_pkg::AOM_SUP_UV_OFF) && uv_hi_s;
    assign ov_done = ov_cond && ov_cnt_reg >= ((sup_reg == aom_pkg::AOM_SUP_NORMAL) ?
                     OV_DET : OV_REC);
    assign uv_done = uv_cond && uv_cnt_reg >= ((sup_reg == aom_pkg::AOM_SUP_NORMAL) ?
                     UV_DET : UV_REC);

    // counters clear whenever their flag drops early
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ov_cnt_reg <= '0;
            uv_cnt_reg <= '0;
        end else begin
            ov_cnt_reg <= (ov_cond && !ov_done && sup_next == sup_reg) ?
                          ov_cnt_reg + 1'b1 : '0;
            uv_cnt_reg <= (uv_cond && !uv_done && sup_next == sup_reg) ?
                          uv_cnt_reg + 1'b1 : '0;
        end
    end

    // overvoltage wins when both trip in the same cycle
    always_comb begin
        sup_next = sup_reg;
        unique case (sup_reg)
            aom_pkg::AOM_SUP_NORMAL: begin
                if (ov_done) begin
                    sup_next = aom_pkg::AOM_SUP_OV_OFF;
                end else if (uv_done) begin
                    sup_next = aom_pkg::AOM_SUP_UV_OFF;
                end
            end
            aom_pkg::AOM_SUP_OV_OFF: begin
                if (ov_done) begin
                    sup_next = aom_pkg::AOM_SUP_NORMAL;
                end
            end
            aom_pkg::AOM_SUP_UV_OFF: begin
                if (uv_done) begin
                    sup_next = aom_pkg::AOM_SUP_NORMAL;
                end
            end
            default: sup_next = aom_pkg::AOM_SUP_NORMAL;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sup_reg <= aom_pkg::AOM_SUP_NORMAL;
        end else begin
            sup_reg <= sup_next;
        end
    end

    // ********************************
    // output characteristic
    // ********************************
    logic [`AOM_ANGLE_W-1:0] angle_reg;
    logic [`AOM_ANGLE_W-1:0] rel_ang;
    logic [`AOM_ANGLE_W-1:0] rel_t1;
    logic [`AOM_ANGLE_W-1:0] rel_t2;
    logic [`AOM_CODE_W-1:0] y_a;
    logic [`AOM_CODE_W-1:0] y_b;
    logic signed [15:0] d_ang;
    logic signed [15:0] d_span;
    logic signed [13:0] d_lvl;
    logic signed [29:0] prod;
    logic signed [29:0] quot;
    logic signed [30:0] lin;
    logic [`AOM_CODE_W-1:0] clamp_lo;
    logic [`AOM_CODE_W-1:0] clamp_hi;
    logic [`AOM_CODE_W-1:0] norm_code;
    logic [`AOM_CODE_W-1:0] band_code;
    logic [`AOM_CODE_W-1:0] code_next;
    logic drive_next;

    // hold the last valid 14-bit angle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            angle_reg <= '0;
        end else if (angle_valid) begin
            angle_reg <= angle_code;
        end
    end

    // angles measured from the break point, so the wrap sits there
    assign rel_ang = angle_reg - cfg.wrap_break_point;
    assign rel_t1 = cfg.angle_start_point - cfg.wrap_break_point;
    assign rel_t2 = cfg.angle_end_point - cfg.wrap_break_point;
    // inversion swaps the level pair, turning the slope round
    assign y_a = cfg.invert ? cfg.end_output_level : cfg.start_output_level;
    assign y_b = cfg.invert ? cfg.start_output_level : cfg.end_output_level;

    // slope from the two pairs, extended past both ends
    assign d_ang = $signed({2'b00, rel_ang}) - $signed({2'b00, rel_t1});
    assign d_span = $signed({2'b00, rel_t2}) - $signed({2'b00, rel_t1});
    assign d_lvl = $signed({2'b00, y_b}) - $signed({2'b00, y_a});
    assign prod = d_ang * d_lvl;
    // a zero span would divide by zero; it just holds y_a, the start level, or the end level when inverted
    assign quot = (d_span == 16'sh0000) ? 30'sh0000_0000 : prod / 30'(d_span);
    assign lin = $signed({19'h00000, y_a}) + $signed({quot[29], quot});

    // nine-bit clamps sit on the top bits of the 12-bit scale
    assign clamp_lo = {cfg.clamp_low_level, 3'h0};
    assign clamp_hi = {cfg.clamp_high_level, 3'h0};
    // with a rising slope the top of the range just before the break point lands on the high clamp, with a falling one on the low clamp
    assign norm_code = (lin < $signed({19'h00000, clamp_lo})) ? clamp_lo :
                       (lin > $signed({19'h00000, clamp_hi})) ? clamp_hi :
                       lin[`AOM_CODE_W-1:0];
    assign band_code = cfg.band_high ? `AOM_BAND_HI_CODE : `AOM_BAND_LO_CODE;
    // internal alarms go to a band; supply and short faults go high impedance
    assign code_next = alarm_s ? band_code : norm_code;
    assign drive_next = (sup_next == aom_pkg::AOM_SUP_NORMAL) && !sc_s;

    // converter code and driver enable leave straight from flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_code <= `AOM_BAND_LO_CODE;
            drive_en <= 1'b0;
        end else begin
            dac_code <= code_next;
            drive_en <= drive_next;
        end
    end

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ov_trip: assert property ((sup_reg == aom_pkg::AOM_SUP_NORMAL) && ov_hi_s
        && ov_cnt_reg == OV_DET |=> sup_reg == aom_pkg::AOM_SUP_OV_OFF && !drive_en)
        else $error("overvoltage did not switch the output off");
    a_ov_recover: assert property ((sup_reg == aom_pkg::AOM_SUP_OV_OFF) && !ov_lo_s
        && ov_cnt_reg == OV_REC |=> sup_reg == aom_pkg::AOM_SUP_NORMAL)
        else $error("overvoltage recovery missed");
    a_uv_trip: assert property ((sup_reg == aom_pkg::AOM_SUP_NORMAL) && !ov_hi_s
        && uv_lo_s && uv_cnt_reg == UV_DET |=> sup_reg == aom_pkg::AOM_SUP_UV_OFF)
        else $error("undervoltage did not switch the output off");
    a_uv_recover: assert property ((sup_reg == aom_pkg::AOM_SUP_UV_OFF) && uv_hi_s
        && uv_cnt_reg == UV_REC |=> sup_reg == aom_pkg::AOM_SUP_NORMAL)
        else $error("undervoltage recovery missed");
    a_cnt_restart: assert property ((sup_reg == aom_pkg::AOM_SUP_NORMAL) && !ov_hi_s
        |=> ov_cnt_reg == '0)
        else $error("detection counter kept running after flag dropped");
    a_off_hiz: assert property (sup_reg != aom_pkg::AOM_SUP_NORMAL |-> !drive_en)
        else $error("driver enabled during supply fault");
    // the driver flop follows the synchronised short one edge later
    a_short_hiz: assert property (sc_s |=> !drive_en)
        else $error("driver enabled during short");
    a_lock_frozen: assert property (locked |=> $stable(otp_reg))
        else $error("locked store changed");
    a_diag_band: assert property (alarm_s |=>
        (dac_code <= `AOM_BAND_LO_MAX) || (dac_code >= `AOM_BAND_HI_MIN))
        else $error("alarm output outside failure band");
    a_band_sel: assert property (alarm_s && cfg.band_high |=>
        dac_code == `AOM_BAND_HI_CODE)
        else $error("high band not selected");
    // rst_n in the antecedent keeps the release edge, where the output flop is still reset, out
    a_clamp_range: assert property (rst_n && !alarm_s && clamp_lo <= clamp_hi |=>
        dac_code >= $past(clamp_lo) && dac_code <= $past(clamp_hi))
        else $error("output left the clamp range");
    // at the end angle the slope must land on the end level, or the start level when inverted
    a_invert_swap: assert property (d_span != 16'sh0000 && rel_ang == rel_t2
        |-> lin == $signed({19'h00000, cfg.invert ? cfg.start_output_level :
        cfg.end_output_level}))
        else $error("end angle does not give the end level");

    c_ov_cycle: cover property (sup_reg == aom_pkg::AOM_SUP_OV_OFF
        ##[1:1000] sup_reg == aom_pkg::AOM_SUP_NORMAL);
    c_uv_off: cover property (sup_reg == aom_pkg::AOM_SUP_UV_OFF);
    c_alarm_band: cover property (alarm_s ##1 dac_code == `AOM_BAND_HI_CODE);
    c_lock_burn: cover property (burn && shadow_reg.lock);

endmodule

// ==== bench/aom_load_model.sv ====
// Purpose: external load reading the output pin
// Assumes: a load resistor pulls the released pin to one rail
// Notes: a released pin shows the pull rail, never the last code
`timescale 1ns/100ps
module aom_load_model #(
    parameter bit PULL_UP = 1'b1
) (
    // driver side
    input wire logic [11:0] dac_code,
    input wire logic drive_en,
    // level seen by the load
    output logic [11:0] seen_level
);
    // ********************************
    // pin level
    // ********************************
    // high impedance lands in the band of the pull rail
    assign seen_level = drive_en ? dac_code : (PULL_UP ? 12'hfff : 12'h000);
endmodule

// ==== bench/aom_top_tb.sv ====
// Purpose: self-checking bench of aom_top
// Assumes: delay counts cut to DLY cycles
// Notes: expected codes worked by hand from the mapping
`timescale 1ns/100ps
`include "aom_params.svh"
module aom_top_tb;
    // ********************************
    // signals and tables
    // ********************************
    localparam int DLY = 20;
    typedef struct packed {
        logic [13:0] bp;
        logic inv;
        logic [13:0] ang;
        logic [11:0] expv;
    } aom_row_s;
    // start 1000 end 3000, levels 100..f00, clamps 200..e00
    localparam aom_row_s ROWS [10] = '{
        '{14'h0, 1'b0, 14'h2000, 12'h800}, '{14'h0, 1'b0, 14'h1800, 12'h480},
        '{14'h0, 1'b0, 14'h1000, 12'h200}, '{14'h0, 1'b0, 14'h3000, 12'he00},
        '{14'h0, 1'b0, 14'h3fff, 12'he00}, '{14'h0, 1'b0, 14'h0000, 12'h200},
        '{14'h0, 1'b0, 14'h0800, 12'h200}, '{14'h1000, 1'b0, 14'h0800, 12'he00},
        '{14'h0, 1'b1, 14'h1800, 12'hb80}, '{14'h0, 1'b1, 14'h1000, 12'he00}};
    localparam logic [39:0] DFLT [8] = '{{8'h00, 32'h0}, {8'h04, 32'h3fff},
        {8'h08, 32'h0}, {8'h0c, 32'hfff}, {8'h10, 32'h20}, {8'h14, 32'h1d8},
        {8'h1c, 32'h0}, {8'h30, 32'h0}};
    localparam logic [39:0] CFG [6] = '{{8'h00, 32'h1000}, {8'h04, 32'h3000},
        {8'h08, 32'h100}, {8'h0c, 32'hf00}, {8'h10, 32'h40}, {8'h14, 32'h1c0}};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [13:0] angle_code = 14'h0;
    logic angle_valid = 1'b0;
    logic ov_above_upper = 1'b0;
    logic ov_above_lower = 1'b0;
    logic uv_below_lower = 1'b0;
    logic uv_above_upper = 1'b1;
    logic short_circuit = 1'b0;
    logic [4:0] internal_alarm = 5'h00;
    logic [11:0] dac_code;
    logic drive_en;
    logic [11:0] seen_level;
    logic [31:0] d;
    int mismatches = 0;
    int total_checks = 0;
    int cyc = 0;

    // ********************************
    // clock, parts and watchdog
    // ********************************
    always #4 clk = ~clk;
    aom_top #(.OV_DET_CYC(DLY), .OV_REC_CYC(DLY), .UV_DET_CYC(DLY), .UV_REC_CYC(DLY)) i_dut (
        .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .angle_code,
        .angle_valid, .ov_above_upper, .ov_above_lower, .uv_below_lower, .uv_above_upper,
        .short_circuit, .internal_alarm, .dac_code, .drive_en);
    aom_load_model #(.PULL_UP(1'b1)) i_load (.dac_code, .drive_en, .seen_level);
    // a hang counts as a mismatch
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end

    // ********************************
    // tasks
    // ********************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s seen %h want %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the read edge
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic ang(input logic [13:0] a);
        @(posedge clk);
        angle_valid <= 1'b1;
        angle_code <= a;
        @(posedge clk);
        angle_valid <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // output must not move before the delay, then must within a bound
    task automatic trip(input logic v);
        int k;
        repeat (16) @(posedge clk);
        #1;
        chk(32'(drive_en), 32'(!v), "early");
        k = 0;
        while (drive_en !== v && k < 24) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(32'(drive_en), 32'(v), "trip");
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rd(DFLT[i][39:32], d);
            chk(d, DFLT[i][31:0], "default");
        end
        chk(32'(drive_en), 32'h1, "drive after reset");
        $display("test reset done");
    endtask

    // ********************************
    // main sequence
    // ********************************
    initial begin
        do_reset();
        // field widths and clamp independence
        wr(`AOM_OFS_BP, 32'hffffffff);
        rd(`AOM_OFS_BP, d);
        chk(d, 32'h3fff, "bp width");
        wr(`AOM_OFS_CLL, 32'hffffffff);
        rd(`AOM_OFS_CLL, d);
        chk(d, 32'h1ff, "cll width");
        rd(`AOM_OFS_CLH, d);
        chk(d, 32'h1d8, "clh kept");
        for (int i = 0; i < 6; i++) begin
            wr(CFG[i][39:32], CFG[i][31:0]);
        end
        for (int i = 0; i < 10; i++) begin
            wr(`AOM_OFS_BP, 32'(ROWS[i].bp));
            wr(`AOM_OFS_CTRL, 32'(ROWS[i].inv));
            ang(ROWS[i].ang);
            chk(32'(dac_code), 32'(ROWS[i].expv), "map");
            chk(32'(seen_level), 32'(ROWS[i].expv), "pin");
        end
        $display("test rows done");
        // each alarm, band alternating
        for (int i = 0; i < 5; i++) begin
            wr(`AOM_OFS_CTRL, {30'h0, i[0], 1'b0});
            internal_alarm <= 5'(1 << i);
            repeat (8) @(posedge clk);
            #1;
            chk(32'(dac_code), i[0] ? 32'hfff : 32'h0, "band");
            chk(32'(drive_en), 32'h1, "band drive");
            internal_alarm <= 5'h00;
            repeat (8) @(posedge clk);
        end
        $display("test alarm done");
        short_circuit <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(32'(seen_level), 32'hfff, "short pin");
        rd(`AOM_OFS_STATUS, d);
        chk(32'(d[17]), 32'h1, "short flag");
        short_circuit <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk(32'(drive_en), 32'h1, "short gone");
        $display("test short done");
        // two bursts shorter than the delay must not trip
        ov_above_lower <= 1'b1;
        repeat (2) begin
            ov_above_upper <= 1'b1;
            repeat (15) @(posedge clk);
            ov_above_upper <= 1'b0;
            repeat (5) @(posedge clk);
        end
        chk(32'(drive_en), 32'h1, "burst");
        ov_above_upper <= 1'b1;
        trip(1'b0);
        rd(`AOM_OFS_STATUS, d);
        chk(32'(d[19:18]), 32'h1, "ov state");
        ov_above_upper <= 1'b0;
        repeat (40) @(posedge clk);
        chk(32'(drive_en), 32'h0, "ov hold");
        ov_above_lower <= 1'b0;
        trip(1'b1);
        uv_above_upper <= 1'b0;
        uv_below_lower <= 1'b1;
        trip(1'b0);
        rd(`AOM_OFS_STATUS, d);
        chk(32'(d[19:18]), 32'h2, "uv state");
        uv_below_lower <= 1'b0;
        repeat (40) @(posedge clk);
        chk(32'(drive_en), 32'h0, "uv hold");
        uv_above_upper <= 1'b1;
        trip(1'b1);
        $display("test supply done");
        wr(`AOM_OFS_CTRL, 32'h4);
        wr(`AOM_OFS_BURN, 32'h1);
        rd(`AOM_OFS_STATUS, d);
        chk(32'(d[14]), 32'h1, "locked");
        wr(`AOM_OFS_CLL, 32'h10);
        rd(`AOM_OFS_CLL, d);
        chk(d, 32'h40, "frozen");
        ang(14'h2000);
        chk(32'(seen_level), 32'h800, "locked map");
        $display("test lock done");
        do_reset();
        print_verdict();
    end
endmodule
